/* fpsch_sched.sv */
// Failure-prediction monitor: mode control, attribute collection, scheduler.
// Function
// - Monitoring mode comes from two bits written on mode page 1Ch.
// - Disable bit set suspends all prediction functions; clear enables them.
// - While enabled, attribute data is counted alongside normal operations.
// - Online-only bit set skips every offline measurement.
// - Rezero command immediately measures offline attributes and saves data.
// - A forced cycle restarts the timer so the next one is an hour later.
// - Log request for page 3Eh returns seconds left until next cycle.
// - Hourly cycle waits for idle interfaces and is interruptible.
// - Online collection delay stays far below 75 ms.
// - Reporting field value one reports predictive failure as 01-5D00.
`timescale 1ns/1ps
module fpsch_sched #(
  parameter int unsigned SEC_CYC = fpsch_pkg::SEC_CYC_DFLT
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          mode_wr,
  input  wire logic [7:0]                    mode_page,
  input  wire logic                          mode_dexcpt,
  input  wire logic                          mode_perf,
  input  wire logic [3:0]                    mode_mrie,
  input  wire logic                          rezero,
  input  wire logic                          log_req,
  input  wire logic [7:0]                    log_page,
  input  wire logic                          if_idle,
  input  wire logic                          op_valid,
  input  wire logic [fpsch_pkg::ATTR_AW-1:0] op_attr,
  input  wire logic                          meas_done,
  input  wire logic                          pf_event,
  input  wire logic [7:0]                    pf_fru,
  output logic                               mon_on_r,
  output logic                               meas_req_r,
  output logic                               save_valid_r,
  output logic [fpsch_pkg::ATTR_AW-1:0]      save_attr_r,
  output logic [fpsch_pkg::ATTR_W-1:0]       save_data_r,
  output logic                               abort_r,
  output logic                               done_r,
  output logic                               log_ack_r,
  output logic                               log_hit_r,
  output logic [15:0]                        log_remain_r,
  output logic                               sense_valid_r,
  output logic [23:0]                        sense_code_r,
  output logic [7:0]                         sense_fru_r
);
  import fpsch_pkg::*;

  // ********************************************************************
  // State and attribute store
  // ********************************************************************
  fpsch_reg_t        q_r;
  fpsch_reg_t        q_nxt;
  logic              mem_we;
  logic [2:0]        mem_waddr;
  logic [15:0]       mem_wdata;
  logic [2:0]        mem_raddr;
  logic [15:0]       mem_rdata;
  logic              op_take;
  logic              sv_issue;
  logic              tick;
  logic              expire;
  logic              quit;

  // Read data one cycle old may miss the write of that cycle.
  // The store has no reset, so the valid bits make a word never written read as zero.
  function automatic logic [15:0] fwd_pick(input fpsch_reg_t s,
                                           input logic [2:0] a,
                                           input logic [15:0] rd);
    fwd_pick = (s.fwd_v && s.fwd_a == a) ? s.fwd_d :
               (s.valid[a] ? rd : 16'h0000);
  endfunction

  fpsch_attr_mem u_mem (
    .ref_clk (ref_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.abort = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.save_valid = 1'b0;
    q_nxt.log_ack = 1'b0;
    q_nxt.sense_valid = 1'b0;
    mem_we = 1'b0;
    mem_waddr = q_r.op_attr;
    mem_wdata = 16'h0000;
    tick = 1'b0;
    expire = 1'b0;
    quit = 1'b0;

    if (mode_wr && mode_page == MODE_PAGE_IEC) begin
      q_nxt.dexcpt = mode_dexcpt;
      q_nxt.perf = mode_perf;
      q_nxt.mrie = mode_mrie;
    end
    q_nxt.mon_on = ~q_r.dexcpt;

    // Online counting owns the read port; saving takes free cycles.
    op_take = op_valid && !q_r.dexcpt;
    sv_issue = !op_take && q_r.st == ST_SAVE && q_r.sv_cnt != ATTR_CNT_END;
    mem_raddr = op_take ? op_attr : q_r.sv_cnt[2:0];
    q_nxt.op_pend = op_take;
    q_nxt.op_attr = op_attr;
    if (q_r.op_pend) begin
      mem_we = 1'b1;
      q_nxt.valid[q_r.op_attr] = 1'b1;
      mem_wdata = fwd_pick(q_r, q_r.op_attr, mem_rdata);
      if (mem_wdata != ATTR_MAX) begin
        mem_wdata = mem_wdata + 16'h0001;
      end
    end
    q_nxt.fwd_v = mem_we;
    q_nxt.fwd_a = mem_waddr;
    q_nxt.fwd_d = mem_wdata;

    // Seconds countdown; held at a full hour while suspended.
    if (q_r.dexcpt) begin
      q_nxt.div = 32'h0000_0000;
      q_nxt.secs = HOUR_SEC;
    end else if (q_r.div == SEC_CYC - 1) begin
      q_nxt.div = 32'h0000_0000;
      tick = 1'b1;
    end else begin
      q_nxt.div = q_r.div + 32'h0000_0001;
    end
    if (tick) begin
      if (q_r.secs <= 16'h0001) begin
        q_nxt.secs = HOUR_SEC;
        expire = 1'b1;
      end else begin
        q_nxt.secs = q_r.secs - 16'h0001;
      end
    end
    if (rezero && !q_r.dexcpt) begin
      q_nxt.div = 32'h0000_0000;
      q_nxt.secs = HOUR_SEC;
    end

    q_nxt.sv_pend = 1'b0;
    case (q_r.st)
      ST_IDLE: begin
        if (rezero && !q_r.dexcpt) begin
          q_nxt.forced = 1'b1;
          q_nxt.sv_cnt = 4'h0;
          q_nxt.st = q_r.perf ? ST_SAVE : ST_MEAS;
          q_nxt.meas_req = !q_r.perf;
        end else if (expire && !q_r.perf) begin
          q_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (q_r.dexcpt || q_r.perf) begin
          q_nxt.st = ST_IDLE;
        end else if (if_idle) begin
          q_nxt.st = ST_MEAS;
          q_nxt.meas_req = 1'b1;
        end
      end
      ST_MEAS: begin
        if (q_r.dexcpt || q_r.perf || !if_idle) begin
          quit = 1'b1;
        end else if (meas_done) begin
          q_nxt.meas_req = 1'b0;
          q_nxt.sv_cnt = 4'h0;
          q_nxt.st = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (q_r.dexcpt || !if_idle) begin
          quit = 1'b1;
        end else begin
          if (q_r.sv_pend) begin
            q_nxt.save_valid = 1'b1;
            q_nxt.save_attr = q_r.sv_idx;
            q_nxt.save_data = fwd_pick(q_r, q_r.sv_idx, mem_rdata);
          end
          if (sv_issue) begin
            q_nxt.sv_pend = 1'b1;
            q_nxt.sv_idx = q_r.sv_cnt[2:0];
            q_nxt.sv_cnt = q_r.sv_cnt + 4'h1;
          end else if (!q_r.sv_pend && q_r.sv_cnt == ATTR_CNT_END) begin
            q_nxt.done = 1'b1;
            q_nxt.forced = 1'b0;
            q_nxt.st = ST_IDLE;
          end
        end
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase
    // An interrupted cycle retries once the interfaces are idle again; with dexcpt or perf set it returns to idle.
    if (quit) begin
      q_nxt.abort = 1'b1;
      q_nxt.meas_req = 1'b0;
      q_nxt.forced = 1'b0;
      q_nxt.st = (q_r.dexcpt || q_r.perf) ? ST_IDLE : ST_WAIT;
    end

    if (log_req) begin
      q_nxt.log_ack = 1'b1;
      q_nxt.log_hit = (log_page == LOG_PAGE_TIMER);
      q_nxt.log_remain = (log_page == LOG_PAGE_TIMER) ? q_r.secs : 16'h0000;
    end
    if (pf_event && !q_r.dexcpt && q_r.mrie == MRIE_SENSE) begin
      q_nxt.sense_valid = 1'b1;
      q_nxt.sense_code = SENSE_PF;
      q_nxt.sense_fru = pf_fru;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.dexcpt <= DEXCPT_RST;
      q_r.perf <= PERF_RST;
      q_r.mrie <= MRIE_RST;
      q_r.secs <= HOUR_SEC;
      q_r.mon_on <= ~DEXCPT_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign mon_on_r      = q_r.mon_on;
  assign meas_req_r    = q_r.meas_req;
  assign save_valid_r  = q_r.save_valid;
  assign save_attr_r   = q_r.save_attr;
  assign save_data_r   = q_r.save_data;
  assign abort_r       = q_r.abort;
  assign done_r        = q_r.done;
  assign log_ack_r     = q_r.log_ack;
  assign log_hit_r     = q_r.log_hit;
  assign log_remain_r  = q_r.log_remain;
  assign sense_valid_r = q_r.sense_valid;
  assign sense_code_r  = q_r.sense_code;
  assign sense_fru_r   = q_r.sense_fru;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_MODE_TAKE: assert property (mode_wr && mode_page == MODE_PAGE_IEC
    |=> q_r.dexcpt == $past(mode_dexcpt) && q_r.perf == $past(mode_perf))
    else $error("Mode page bits not taken.");
  AST_SUSPEND: assert property (q_r.dexcpt ##1 q_r.dexcpt
    |-> !meas_req_r && !save_valid_r && !mon_on_r)
    else $error("Monitoring active while disabled.");
  AST_ONLINE: assert property (op_valid && !q_r.dexcpt
    |=> mem_we && mem_waddr == $past(op_attr))
    else $error("Operation not counted in next cycle.");
  AST_PERF: assert property (q_r.perf ##1 q_r.perf |-> !meas_req_r)
    else $error("Offline measurement in online-only mode.");
  AST_REZERO: assert property (rezero && !q_r.dexcpt && !q_r.perf
    && q_r.st == ST_IDLE |=> meas_req_r)
    else $error("Forced measurement did not start.");
  AST_RESTART: assert property (rezero && !q_r.dexcpt
    |=> q_r.secs == HOUR_SEC && q_r.div == 32'h0000_0000)
    else $error("Timer not restarted by rezero.");
  AST_LOG: assert property (log_req && log_page == LOG_PAGE_TIMER
    |=> log_ack_r && log_hit_r && log_remain_r == $past(q_r.secs))
    else $error("Remaining time not returned.");
  AST_IDLE_WAIT: assert property (q_r.st == ST_WAIT && !if_idle
    |=> !meas_req_r)
    else $error("Scheduled cycle started on busy interfaces.");
  AST_INTERRUPT: assert property (meas_req_r && !if_idle
    |=> abort_r && !meas_req_r)
    else $error("Measurement not interrupted by activity.");
  AST_LATENCY: assert property (q_r.op_pend |-> mem_we
    && mem_wdata != 16'h0000 && ONLINE_LAT_CYC < ONLINE_MAX_CYC)
    else $error("Online update late.");
  AST_SENSE: assert property (pf_event && !q_r.dexcpt
    && q_r.mrie == MRIE_SENSE |=> sense_valid_r && sense_code_r == SENSE_PF)
    else $error("Predictive failure sense not reported.");
  AST_ABANDON: assert property (q_r.st == ST_SAVE && q_r.dexcpt
    |=> q_r.st == ST_IDLE && abort_r)
    else $error("Cycle not abandoned on disable.");

  COV_FORCED: cover property (rezero && q_r.st == ST_IDLE ##[1:300] done_r);
  COV_SCHED: cover property (q_r.st == ST_WAIT ##1 meas_req_r);
  COV_ABORT: cover property (meas_req_r ##1 abort_r);
  COV_LOG: cover property (log_req ##1 log_hit_r);

endmodule // fpsch_sched

/* fpsch_pkg.sv */
// Package of constants and types for the failure-prediction scheduler.
package fpsch_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned SEC_CYC_DFLT  = CLK_HZ;
  localparam logic [15:0] HOUR_SEC      = 16'h0E10;
  localparam int unsigned ONLINE_MAX_MS = 75;
  localparam int unsigned ONLINE_MAX_CYC = ONLINE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned ONLINE_LAT_CYC = 1;

  // ********************************************************************
  // Pages, fields and codes
  // ********************************************************************
  localparam logic [7:0]  MODE_PAGE_IEC  = 8'h1C;
  localparam logic [7:0]  LOG_PAGE_TIMER = 8'h3E;
  localparam logic [3:0]  MRIE_SENSE     = 4'h1;
  localparam logic [3:0]  MRIE_RST       = 4'h0;
  localparam logic        DEXCPT_RST     = 1'b0;
  localparam logic        PERF_RST       = 1'b0;
  localparam logic [23:0] SENSE_PF       = 24'h015D00;

  // ********************************************************************
  // Attribute store
  // ********************************************************************
  localparam int unsigned ATTR_N  = 8;
  localparam int unsigned ATTR_AW = 3;
  localparam int unsigned ATTR_W  = 16;
  localparam logic [15:0] ATTR_MAX = 16'hFFFF;
  localparam logic [3:0]  ATTR_CNT_END = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_MEAS,
    ST_SAVE
  } fpsch_state_t;

  typedef struct packed {
    fpsch_state_t st;
    logic         dexcpt;
    logic         perf;
    logic [3:0]   mrie;
    logic [31:0]  div;
    logic [15:0]  secs;
    logic         forced;
    logic         op_pend;
    logic [2:0]   op_attr;
    logic         fwd_v;
    logic [2:0]   fwd_a;
    logic [15:0]  fwd_d;
    logic         sv_pend;
    logic [2:0]   sv_idx;
    logic [3:0]   sv_cnt;
    logic         meas_req;
    logic         save_valid;
    logic [2:0]   save_attr;
    logic [15:0]  save_data;
    logic         abort;
    logic         done;
    logic         log_ack;
    logic         log_hit;
    logic [15:0]  log_remain;
    logic         sense_valid;
    logic [23:0]  sense_code;
    logic [7:0]   sense_fru;
    logic         mon_on;
    logic [7:0]   valid;
  } fpsch_reg_t;

endpackage

/* fpsch_attr_mem.sv */
// Attribute counter store with a registered read port.
`timescale 1ns/1ps
module fpsch_attr_mem (
  input  wire logic                           ref_clk,
  input  wire logic                           we,
  input  wire logic [fpsch_pkg::ATTR_AW-1:0]  waddr,
  input  wire logic [fpsch_pkg::ATTR_W-1:0]   wdata,
  input  wire logic [fpsch_pkg::ATTR_AW-1:0]  raddr,
  output logic      [fpsch_pkg::ATTR_W-1:0]   rdata
);
  import fpsch_pkg::*;

  // Reads return the old word on a same-address write; the caller forwards.
  logic [ATTR_W-1:0] mem [ATTR_N];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // fpsch_attr_mem

/* fpsch_host_model.sv */
// Host model that issues mode, log and rezero commands.
`timescale 1ns/1ps
module fpsch_host_model (
  input  wire logic       ref_clk,
  output logic            mode_wr,
  output logic [7:0]      mode_page,
  output logic            mode_dexcpt,
  output logic            mode_perf,
  output logic [3:0]      mode_mrie,
  output logic            rezero,
  output logic            log_req,
  output logic [7:0]      log_page
);
  // ****************************************
  // Command tasks
  // ****************************************
  // Released fields show inverted data so stale values never look valid.
  initial begin
    {mode_wr, rezero, log_req} = 3'h0;
    {mode_page, mode_dexcpt, mode_perf, mode_mrie, log_page} = 22'h0;
  end

  task automatic mode_write(input logic [7:0] pg, input logic dx,
                            input logic pf, input logic [3:0] mr);
    @(negedge ref_clk);
    {mode_wr, mode_page, mode_dexcpt, mode_perf, mode_mrie} =
      {1'b1, pg, dx, pf, mr};
    @(negedge ref_clk);
    {mode_wr, mode_page, mode_dexcpt, mode_perf, mode_mrie} =
      {1'b0, ~pg, ~dx, ~pf, ~mr};
  endtask

  task automatic force_cycle();
    @(negedge ref_clk);
    rezero = 1'b1;
    @(negedge ref_clk);
    rezero = 1'b0;
  endtask

  task automatic log_sense(input logic [7:0] pg);
    @(negedge ref_clk);
    {log_req, log_page} = {1'b1, pg};
    @(negedge ref_clk);
    {log_req, log_page} = {1'b0, ~pg};
  endtask
endmodule // fpsch_host_model

/* tb_top.sv */
// Self-checking testbench for the failure-prediction scheduler.
`timescale 1ns/1ps
module tb_top;
  import fpsch_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  // A short second keeps the hourly wait inside the run budget.
  localparam int unsigned SC       = 8;
  localparam int          HOUR_CYC = 3600 * SC;
  typedef struct packed {
    logic [2:0]  k;
    logic [31:0] v;
  } fpsch_exp_t;
  logic        ref_clk, rst, if_idle, op_valid, meas_done, pf_event;
  logic        mode_wr, mode_dexcpt, mode_perf, rezero, log_req;
  logic [7:0]  mode_page, log_page, pf_fru, sense_fru_r;
  logic [3:0]  mode_mrie;
  logic [2:0]  op_attr, save_attr_r;
  logic        mon_on_r, meas_req_r, save_valid_r, abort_r, done_r;
  logic        log_ack_r, log_hit_r, sense_valid_r, saw_meas;
  logic [15:0] save_data_r, log_remain_r;
  logic [23:0] sense_code_r;
  logic [15:0] cnt [8];
  fpsch_exp_t  q [$];
  int          n_errors, checks_done, cyc;

  fpsch_host_model host (.ref_clk, .mode_wr, .mode_page, .mode_dexcpt,
    .mode_perf, .mode_mrie, .rezero, .log_req, .log_page);
  fpsch_sched #(.SEC_CYC(SC)) uut (.ref_clk, .rst, .mode_wr, .mode_page,
    .mode_dexcpt, .mode_perf, .mode_mrie, .rezero, .log_req, .log_page,
    .if_idle, .op_valid, .op_attr, .meas_done, .pf_event, .pf_fru,
    .mon_on_r, .meas_req_r, .save_valid_r, .save_attr_r, .save_data_r,
    .abort_r, .done_r, .log_ack_r, .log_hit_r, .log_remain_r,
    .sense_valid_r, .sense_code_r, .sense_fru_r);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic push(input logic [2:0] k, input logic [31:0] v);
    q.push_back('{k, v});
  endtask

  task automatic take(input logic [2:0] k, input logic [31:0] v);
    fpsch_exp_t e;
    if (q.size() == 0) begin
      chk("unexpected result kind", 32'h0, k);
    end else begin
      e = q.pop_front();
      chk("result kind", e.k, k);
      chk("result value", e.v, v);
    end
  endtask

  task automatic push_saves();
    for (int i = 0; i < 8; i++) push(3'h3, {13'h0, 3'(i), cnt[i]});
    push(3'h4, 32'h0);
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && q.size() > 0; i++) @(negedge ref_clk);
    chk("pending results", 32'h0, q.size());
  endtask

  task automatic ops(input int n, input logic en);
    logic [2:0] a;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      a = 3'($urandom);
      op_valid = 1'b1;
      op_attr = a;
      if (en && cnt[a] != 16'hFFFF) cnt[a]++;
    end
    @(negedge ref_clk);
    op_valid = 1'b0;
  endtask

  task automatic pf(input logic hit);
    @(negedge ref_clk);
    pf_fru = 8'($urandom);
    pf_event = 1'b1;
    if (hit) push(3'h2, {SENSE_PF, pf_fru});
    @(negedge ref_clk);
    pf_event = 1'b0;
  endtask

  task automatic log(input logic [7:0] pg, input logic [16:0] e);
    push(3'h1, {15'h0, e});
    host.log_sense(pg);
  endtask

  task automatic wait_meas();
    for (int i = 0; i < 20 && meas_req_r !== 1'b1; i++) @(negedge ref_clk);
    chk("meas_req_r", 32'h1, meas_req_r);
  endtask

  // ****************************************
  // Clock, monitor and measurement engine
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  always @(negedge ref_clk) begin
    if (rst === 1'b0) begin
      if (meas_req_r === 1'b1) saw_meas = 1'b1;
      if (save_valid_r === 1'b1) take(3'h3, {13'h0, save_attr_r, save_data_r});
      if (done_r === 1'b1) take(3'h4, 32'h0);
      if (abort_r === 1'b1) take(3'h5, 32'h0);
      if (log_ack_r === 1'b1) take(3'h1, {15'h0, log_hit_r, log_remain_r});
      if (sense_valid_r === 1'b1) take(3'h2, {sense_code_r, sense_fru_r});
    end
  end

  initial begin
    meas_done = 1'b0;
    forever begin
      @(posedge ref_clk iff meas_req_r === 1'b1);
      repeat (4) @(negedge ref_clk);
      meas_done = 1'b1;
      @(negedge ref_clk);
      meas_done = 1'b0;
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int t0;
    {rst, if_idle, op_valid, op_attr, pf_event, pf_fru} = 15'h6000;
    {n_errors, checks_done, cyc, saw_meas} = 0;
    foreach (cnt[i]) cnt[i] = 16'h0;
    void'($urandom(32'hE0EA9A8D));
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    chk("mon_on_r", 32'h1, mon_on_r);
    log(LOG_PAGE_TIMER, {1'b1, HOUR_SEC});
    log(8'h3D, 17'h0);
    for (int m = 0; m < 16; m++) begin
      host.mode_write(MODE_PAGE_IEC, 1'b0, 1'b0, 4'(m));
      pf(m == 1);
    end
    host.mode_write(MODE_PAGE_IEC, 1'b0, 1'b0, MRIE_SENSE);
    host.mode_write(8'h1D, 1'b0, 1'b0, 4'h2);
    pf(1'b1);
    ops(40, 1'b1);
    host.force_cycle();
    t0 = cyc;
    log(LOG_PAGE_TIMER, {1'b1, HOUR_SEC});
    push_saves();
    drain();
    wait (cyc >= t0 + HOUR_CYC - 24);
    @(negedge ref_clk);
    chk("meas_req_r early", 32'h0, meas_req_r);
    if_idle = 1'b0;
    wait (cyc >= t0 + HOUR_CYC + 16);
    @(negedge ref_clk);
    chk("meas_req_r busy", 32'h0, meas_req_r);
    push_saves();
    if_idle = 1'b1;
    wait_meas();
    drain();
    host.mode_write(MODE_PAGE_IEC, 1'b0, 1'b1, MRIE_SENSE);
    saw_meas = 1'b0;
    push_saves();
    host.force_cycle();
    drain();
    chk("measure in online-only mode", 32'h0, saw_meas);
    host.mode_write(MODE_PAGE_IEC, 1'b1, 1'b0, MRIE_SENSE);
    repeat (2) @(negedge ref_clk);
    chk("mon_on_r", 32'h0, mon_on_r);
    ops(20, 1'b0);
    pf(1'b0);
    host.force_cycle();
    repeat (100) @(negedge ref_clk);
    log(LOG_PAGE_TIMER, {1'b1, HOUR_SEC});
    host.mode_write(8'h1D, 1'b0, 1'b0, MRIE_SENSE);
    repeat (2) @(negedge ref_clk);
    chk("mon_on_r", 32'h0, mon_on_r);
    host.mode_write(MODE_PAGE_IEC, 1'b0, 1'b0, MRIE_SENSE);
    push_saves();
    host.force_cycle();
    drain();
    // A disable in mid-measure must end the cycle with an abort pulse.
    host.force_cycle();
    wait_meas();
    push(3'h5, 32'h0);
    host.mode_write(MODE_PAGE_IEC, 1'b1, 1'b0, MRIE_SENSE);
    drain();
    host.mode_write(MODE_PAGE_IEC, 1'b0, 1'b0, MRIE_SENSE);
    host.force_cycle();
    wait_meas();
    push(3'h5, 32'h0);
    if_idle = 1'b0;
    drain();
    repeat (20) @(negedge ref_clk);
    print_verdict();
  end
endmodule // tb_top
